// [radio_startup_and_freq_comp_cfg.sv]
// start-up timeout sequencer and frequency compensation configuration registers
`timescale 1ns/1ps
module radio_startup_and_freq_comp_cfg #(
  parameter int OFFSET_W = 16
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic [5:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic osc_stable_i,
  input wire logic sleep_i,
  input wire logic carrier_sense_i,
  input wire logic sync_found_i,
  input wire logic signed [OFFSET_W-1:0] freq_offset_i,
  input wire logic [OFFSET_W-2:0] channel_bandwidth_i,
  output logic chip_ready_low_o,
  output logic crystal_oscillator_en_o,
  output logic pin_ctrl_en_o,
  output logic loop_freeze_o,
  output logic [3:0] freq_gain_o,
  output logic freq_comp_en_o,
  output logic signed [OFFSET_W-1:0] freq_offset_comp_o
);

  if (OFFSET_W < 4 || OFFSET_W > 32) begin
    $error("OFFSET_W out of range");
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [8:0] expiry_target(input logic [1:0] sel);
    unique case (sel)
      2'h0: expiry_target = radio_cfg_pkg::EXPIRY_1;
      2'h1: expiry_target = radio_cfg_pkg::EXPIRY_16;
      2'h2: expiry_target = radio_cfg_pkg::EXPIRY_64;
      2'h3: expiry_target = radio_cfg_pkg::EXPIRY_256;
    endcase
  endfunction

  // pre-sync gain code n gives (n+1)K, here in K/2 units
  function automatic logic [3:0] pre_gain(input logic [1:0] sel);
    pre_gain = {1'b0, sel + 2'h1, 1'b0} ^ {sel == 2'h3, 3'h0};
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [1:0] wait_sel_ff;
  logic pin_ctrl_ff;
  logic osc_keep_ff;
  logic cs_gate_ff;
  logic [1:0] gain_pre_ff;
  logic gain_post_ff;
  logic [1:0] sat_ff;

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wait_sel_ff <= radio_cfg_pkg::WAIT_SEL_RST;
      pin_ctrl_ff <= radio_cfg_pkg::PIN_CTRL_RST;
      osc_keep_ff <= radio_cfg_pkg::OSC_KEEP_RST;
    end else if (reg_wr_i && reg_addr_i == radio_cfg_pkg::SEQ_CFG_LOW_ADDR) begin
      wait_sel_ff <= reg_wdata_i[radio_cfg_pkg::WAIT_SEL_LSB +: 2];
      pin_ctrl_ff <= reg_wdata_i[radio_cfg_pkg::PIN_CTRL_BIT];
      osc_keep_ff <= reg_wdata_i[radio_cfg_pkg::OSC_KEEP_BIT];
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cs_gate_ff <= radio_cfg_pkg::CS_GATE_RST;
      gain_pre_ff <= radio_cfg_pkg::GAIN_PRE_RST;
      gain_post_ff <= radio_cfg_pkg::GAIN_POST_RST;
      sat_ff <= radio_cfg_pkg::SAT_RST;
    end else if (reg_wr_i && reg_addr_i == radio_cfg_pkg::FOC_CFG_ADDR) begin
      cs_gate_ff <= reg_wdata_i[radio_cfg_pkg::CS_GATE_BIT];
      gain_pre_ff <= reg_wdata_i[radio_cfg_pkg::GAIN_PRE_LSB +: 2];
      gain_post_ff <= reg_wdata_i[radio_cfg_pkg::GAIN_POST_BIT];
      sat_ff <= reg_wdata_i[radio_cfg_pkg::SAT_LSB +: 2];
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  logic [7:0] nxt_rdata;

  always_comb begin
    nxt_rdata = 8'h00;
    if (reg_addr_i == radio_cfg_pkg::SEQ_CFG_LOW_ADDR) begin
      nxt_rdata[radio_cfg_pkg::WAIT_SEL_LSB +: 2] = wait_sel_ff;
      nxt_rdata[radio_cfg_pkg::PIN_CTRL_BIT] = pin_ctrl_ff;
      nxt_rdata[radio_cfg_pkg::OSC_KEEP_BIT] = osc_keep_ff;
    end else if (reg_addr_i == radio_cfg_pkg::FOC_CFG_ADDR) begin
      nxt_rdata[radio_cfg_pkg::CS_GATE_BIT] = cs_gate_ff;
      nxt_rdata[radio_cfg_pkg::GAIN_PRE_LSB +: 2] = gain_pre_ff;
      nxt_rdata[radio_cfg_pkg::GAIN_POST_BIT] = gain_post_ff;
      nxt_rdata[radio_cfg_pkg::SAT_LSB +: 2] = sat_ff;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------
  // oscillator stable synchroniser
  // ----------------------------------------------------------------
  logic osc_meta_ff;
  logic osc_sync_ff;

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      osc_meta_ff <= 1'b0;
      osc_sync_ff <= 1'b0;
    end else begin
      osc_meta_ff <= osc_stable_i;
      osc_sync_ff <= osc_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // start-up sequencer
  // ----------------------------------------------------------------
  radio_cfg_pkg::startup_state_t state_ff;
  logic [radio_cfg_pkg::RIPPLE_BITS-1:0] ripple_ff;
  logic [radio_cfg_pkg::EXPIRY_BITS-1:0] expiry_ff;
  logic ripple_wrap;
  logic count_done;

  assign ripple_wrap = &ripple_ff;
  assign count_done = ripple_wrap && (expiry_ff + 9'h001 >= expiry_target(wait_sel_ff)); // [RULE1]

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_ff <= radio_cfg_pkg::ST_WAIT_OSC;
    end else if (!osc_sync_ff) begin
      state_ff <= radio_cfg_pkg::ST_WAIT_OSC;
    end else begin
      unique case (state_ff)
        radio_cfg_pkg::ST_WAIT_OSC: state_ff <= radio_cfg_pkg::ST_COUNT;
        radio_cfg_pkg::ST_COUNT: begin
          if (count_done) begin
            state_ff <= radio_cfg_pkg::ST_READY;
          end
        end
        radio_cfg_pkg::ST_READY: state_ff <= radio_cfg_pkg::ST_READY;
        default: state_ff <= radio_cfg_pkg::ST_WAIT_OSC;
      endcase
    end
  end

  // six-bit ripple counter and expiry tally [RULE2]
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ripple_ff <= '0;
      expiry_ff <= '0;
    end else if (state_ff != radio_cfg_pkg::ST_COUNT) begin
      ripple_ff <= '0;
      expiry_ff <= '0;
    end else begin
      ripple_ff <= ripple_ff + 6'h01;
      if (ripple_wrap) begin
        expiry_ff <= expiry_ff + 9'h001;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      chip_ready_low_o <= 1'b1;
    end else begin
      chip_ready_low_o <= !(osc_sync_ff && state_ff == radio_cfg_pkg::ST_READY); // [RULE2]
    end
  end

  // ----------------------------------------------------------------
  // oscillator and pin control
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      crystal_oscillator_en_o <= 1'b1;
      pin_ctrl_en_o <= 1'b0;
    end else begin
      crystal_oscillator_en_o <= !sleep_i || osc_keep_ff; // [RULE8]
      pin_ctrl_en_o <= pin_ctrl_ff;
    end
  end

  // ----------------------------------------------------------------
  // frequency compensation loop control
  // ----------------------------------------------------------------
  logic signed [OFFSET_W-1:0] clamped;

  freq_offset_clamp #(
    .W(OFFSET_W)
  ) u_clamp (
    .offset_i(freq_offset_i),
    .bandwidth_i(channel_bandwidth_i),
    .sat_sel_i(sat_ff),
    .clamped_o(clamped)
  );

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      loop_freeze_o <= 1'b1;
      freq_gain_o <= 4'h6;
      freq_comp_en_o <= 1'b1;
      freq_offset_comp_o <= '0;
    end else begin
      loop_freeze_o <= cs_gate_ff && !carrier_sense_i; // [RULE3]
      if (sync_found_i && gain_post_ff) begin
        freq_gain_o <= radio_cfg_pkg::GAIN_HALF_K; // [RULE5]
      end else begin
        freq_gain_o <= pre_gain(gain_pre_ff); // [RULE4]
      end
      freq_comp_en_o <= sat_ff != 2'h0; // [RULE6]
      freq_offset_comp_o <= clamped; // [RULE6]
    end
  end

endmodule

// [radio_cfg_pkg.sv]
// constants and register layout of the start-up and frequency compensation configuration
//
// Contract
// [RULE1] The power-on wait field picks 1, 16, 64 or 256 ripple-counter expiries for codes 0 to 3.
// [RULE2] Chip-ready-low stays high until the six-bit ripple counter has expired that many times.
// [RULE3] With carrier gating set, frequency and clock recovery loops stay frozen until carrier sense.
// [RULE4] The pre-sync gain field, reset 2, gives K, 2K, 3K or 4K for codes 0 to 3.
// [RULE5] After sync the post-sync bit, reset 1, keeps the pre-sync gain when 0 or gives K/2 when 1.
// [RULE6] The limit field, bits 1:0 reset 2, gives none, bandwidth/8, bandwidth/4 or bandwidth/2.
// [RULE7] The host writes the limit field as zero whenever on-off or amplitude keying is in use.
// [RULE8] With force-on set the oscillator keeps running in sleep; when clear it may stop there.
package radio_cfg_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [5:0] SEQ_CFG_LOW_ADDR = 6'h18;
  localparam logic [5:0] FOC_CFG_ADDR = 6'h19;

  // ----------------------------------------------------------------
  // radio_sequencer_cfg_low fields
  // ----------------------------------------------------------------
  localparam int WAIT_SEL_LSB = 2;
  localparam int PIN_CTRL_BIT = 1;
  localparam int OSC_KEEP_BIT = 0;
  localparam logic [1:0] WAIT_SEL_RST = 2'h1;
  localparam logic PIN_CTRL_RST = 1'b0;
  localparam logic OSC_KEEP_RST = 1'b0;

  // ----------------------------------------------------------------
  // freq_offset_comp_cfg fields
  // ----------------------------------------------------------------
  localparam int CS_GATE_BIT = 5;
  localparam int GAIN_PRE_LSB = 3;
  localparam int GAIN_POST_BIT = 2;
  localparam int SAT_LSB = 0;
  localparam logic CS_GATE_RST = 1'b1;
  localparam logic [1:0] GAIN_PRE_RST = 2'h2;
  localparam logic GAIN_POST_RST = 1'b1;
  localparam logic [1:0] SAT_RST = 2'h2;

  // ----------------------------------------------------------------
  // start-up counting
  // ----------------------------------------------------------------
  localparam int RIPPLE_BITS = 6;
  localparam int EXPIRY_BITS = 9;
  localparam logic [8:0] EXPIRY_1 = 9'h001;
  localparam logic [8:0] EXPIRY_16 = 9'h010;
  localparam logic [8:0] EXPIRY_64 = 9'h040;
  localparam logic [8:0] EXPIRY_256 = 9'h100;

  // ----------------------------------------------------------------
  // loop gain in units of K/2
  // ----------------------------------------------------------------
  localparam logic [3:0] GAIN_HALF_K = 4'h1;

  typedef enum logic [2:0] {
    ST_WAIT_OSC = 3'b001,
    ST_COUNT = 3'b010,
    ST_READY = 3'b100
  } startup_state_t;

endpackage

// [freq_offset_clamp.sv]
// saturation of the compensated frequency offset
`timescale 1ns/1ps
module freq_offset_clamp #(
  parameter int W = 16
) (
  input wire logic signed [W-1:0] offset_i,
  input wire logic [W-2:0] bandwidth_i,
  input wire logic [1:0] sat_sel_i,
  output logic signed [W-1:0] clamped_o
);

  if (W < 4) begin
    $error("offset width too small");
  end

  logic signed [W-1:0] limit;

  // bandwidth divided by 8, 4 or 2, or zero limit [RULE6]
  always_comb begin
    unique case (sat_sel_i)
      2'h0: limit = '0;
      2'h1: limit = signed'({1'b0, bandwidth_i >> 3});
      2'h2: limit = signed'({1'b0, bandwidth_i >> 2});
      2'h3: limit = signed'({1'b0, bandwidth_i >> 1});
    endcase
  end

  always_comb begin
    if (offset_i > limit) begin
      clamped_o = limit;
    end else if (offset_i < -limit) begin
      clamped_o = -limit;
    end else begin
      clamped_o = offset_i;
    end
  end

endmodule

// [radio_cfg_sva.sv]
// checker for the start-up and frequency compensation configuration block
`timescale 1ns/1ps
module radio_cfg_sva #(
  parameter int OFFSET_W = 16
) (
  input wire logic sys_clk_i, rst_b_i, reg_wr_i, osc_stable_i, sleep_i,
  input wire logic carrier_sense_i, sync_found_i,
  input wire logic [5:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic signed [OFFSET_W-1:0] freq_offset_i,
  input wire logic [OFFSET_W-2:0] channel_bandwidth_i,
  input wire logic chip_ready_low_o, crystal_oscillator_en_o, loop_freeze_o, freq_comp_en_o,
  input wire logic [3:0] freq_gain_o,
  input wire logic signed [OFFSET_W-1:0] freq_offset_comp_o
);
  logic [7:0] seq_ff, foc_ff;
  logic [14:0] up_ff, wait_c;
  logic [3:0] gain_c;
  logic osc_c;
  logic signed [OFFSET_W:0] lim_c, clamp_c;
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      seq_ff <= 8'h04;
      foc_ff <= 8'h36;
    end else if (reg_wr_i && reg_addr_i == 6'h18) begin
      seq_ff <= reg_wdata_i;
    end else if (reg_wr_i && reg_addr_i == 6'h19) begin
      foc_ff <= reg_wdata_i;
    end
  end
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      up_ff <= 15'h0000;
    end else if (!osc_stable_i) begin
      up_ff <= 15'h0000;
    end else if (up_ff != 15'h7FFF) begin
      up_ff <= up_ff + 15'h0001;
    end
  end
  always_comb begin
    case (seq_ff[3:2])
      2'h0: wait_c = 15'h0040;
      2'h1: wait_c = 15'h0400;
      2'h2: wait_c = 15'h1000;
      default: wait_c = 15'h4000;
    endcase
    gain_c = (sync_found_i && foc_ff[2]) ? 4'h1 : {1'b0, foc_ff[4:3], 1'b0} + 4'h2;
    osc_c = !sleep_i || seq_ff[0];
    lim_c = $signed({2'b00, channel_bandwidth_i >> (3'h4 - foc_ff[1:0])});
    if (foc_ff[1:0] == 2'h0) lim_c = '0;
    clamp_c = (OFFSET_W+1)'(freq_offset_i);
    if (clamp_c > lim_c) clamp_c = lim_c;
    if (clamp_c < -lim_c) clamp_c = -lim_c;
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence ready_fall;
    $fell(chip_ready_low_o);
  endsequence
  sequence osc_lost;
    $fell(osc_stable_i) ##1 !osc_stable_i;
  endsequence
  a_ready_wait_count: assert property (ready_fall |-> up_ff >= wait_c)
    else $error("chip ready came before the programmed start-up wait");
  a_ready_drops_again: assert property (osc_lost |-> ##[0:4] chip_ready_low_o)
    else $error("chip ready stayed low after oscillator loss");
  a_ready_osc_low: assert property (!osc_stable_i [*6] |-> chip_ready_low_o)
    else $error("chip ready low without stable oscillator");
  a_freeze_gate_on: assert property (foc_ff[5] && !carrier_sense_i |=> loop_freeze_o)
    else $error("loops not frozen while gated without carrier");
  a_freeze_on_carrier: assert property (carrier_sense_i |=> !loop_freeze_o)
    else $error("loops frozen with carrier sensed");
  a_gain_pre_sync: assert property (!sync_found_i |=> freq_gain_o == $past(gain_c))
    else $error("pre-sync loop gain wrong");
  a_gain_post_sync: assert property (sync_found_i |=> freq_gain_o == $past(gain_c))
    else $error("post-sync loop gain wrong");
  a_sat_enable: assert property (##1 freq_comp_en_o == ($past(foc_ff[1:0]) != 2'h0))
    else $error("compensation enable does not follow limit field");
  a_offset_clamp: assert property (##1 freq_offset_comp_o == $past(clamp_c[OFFSET_W-1:0]))
    else $error("compensated offset not clamped as programmed");
  a_osc_keep_sleep: assert property (##1 crystal_oscillator_en_o == $past(osc_c))
    else $error("oscillator enable wrong for sleep and force-on");
endmodule
bind radio_startup_and_freq_comp_cfg radio_cfg_sva #(.OFFSET_W(OFFSET_W)) radio_cfg_sva_i (
  .sys_clk_i, .rst_b_i, .reg_wr_i, .osc_stable_i, .sleep_i, .carrier_sense_i, .sync_found_i,
  .reg_addr_i, .reg_wdata_i, .freq_offset_i, .channel_bandwidth_i, .chip_ready_low_o,
  .crystal_oscillator_en_o, .loop_freeze_o, .freq_comp_en_o, .freq_gain_o, .freq_offset_comp_o);

// [radio_startup_and_freq_comp_cfg_tb.sv]
// self-checking bench for the start-up and frequency compensation configuration block
`timescale 1ns/1ps
module radio_startup_and_freq_comp_cfg_tb;
  logic sys_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [5:0] reg_addr_i = 6'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, osc_stable_i = 1'b0, sleep_i = 1'b0;
  logic carrier_sense_i = 1'b0, sync_found_i = 1'b0, in_range = 1'b0;
  logic signed [15:0] freq_offset_i = 16'h0000;
  logic [14:0] channel_bandwidth_i = 15'h0000;
  logic [7:0] reg_rdata_o;
  logic chip_ready_low_o, crystal_oscillator_en_o, pin_ctrl_en_o, loop_freeze_o, freq_comp_en_o;
  logic [3:0] freq_gain_o;
  logic signed [15:0] freq_offset_comp_o;
  logic [15:0] exp_q[$];
  int sel_q[$];
  int mismatches = 0;
  int n_tests = 0;
  int seed, cnt, lim, s;
  event look;
  string nm[9] = '{"rdata", "ready_low", "osc_en", "pin_ctrl", "freeze", "gain", "comp_en",
                   "offset", "startup"};
  always #2 sys_clk_i = ~sys_clk_i;
  radio_startup_and_freq_comp_cfg radio_startup_and_freq_comp_cfg_i (
    .sys_clk_i, .rst_b_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .osc_stable_i, .sleep_i, .carrier_sense_i, .sync_found_i, .freq_offset_i,
    .channel_bandwidth_i, .chip_ready_low_o, .crystal_oscillator_en_o, .pin_ctrl_en_o,
    .loop_freeze_o, .freq_gain_o, .freq_comp_en_o, .freq_offset_comp_o);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic print_verdict;
    if (mismatches == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [15:0] obs(int k);
    case (k)
      0: return {8'h00, reg_rdata_o};
      1: return {15'h0000, chip_ready_low_o};
      2: return {15'h0000, crystal_oscillator_en_o};
      3: return {15'h0000, pin_ctrl_en_o};
      4: return {15'h0000, loop_freeze_o};
      5: return {12'h000, freq_gain_o};
      6: return {15'h0000, freq_comp_en_o};
      7: return freq_offset_comp_o;
      default: return {15'h0000, in_range};
    endcase
  endfunction
  function automatic logic [15:0] clamp_exp(logic [1:0] sat);
    logic signed [16:0] l, o;
    l = (sat == 2'h0) ? 17'sh00000 : $signed({2'h0, channel_bandwidth_i >> (3'h4 - sat)});
    o = 17'(freq_offset_i);
    if (o > l) o = l;
    if (o < -l) o = -l;
    return o[15:0];
  endfunction
  task automatic exp_out(int k, logic [15:0] v);
    sel_q.push_back(k);
    exp_q.push_back(v);
    -> look;
  endtask
  task automatic wr(logic [5:0] a, logic [7:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(logic [5:0] a, logic [7:0] e);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1 exp_out(0, {8'h00, e});
  endtask
  task automatic drv(logic cs, logic sy, logic sl);
    @(posedge sys_clk_i);
    carrier_sense_i <= cs;
    sync_found_i <= sy;
    sleep_i <= sl;
    freq_offset_i <= 16'($urandom);
    channel_bandwidth_i <= 15'($urandom);
    repeat (3) @(posedge sys_clk_i);
    #1;
  endtask
  // ----------------------------------------------------------------
  // result watcher
  // ----------------------------------------------------------------
  initial forever begin
    @look;
    while (sel_q.size() > 0) begin
      s = sel_q.pop_front();
      check(nm[s], obs(s), exp_q.pop_front());
    end
  end
  // stop after about twice the longest expected run
  initial begin
    #200000;
    mismatches++;
    print_verdict;
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    seed = $urandom(68);
    repeat (20) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    wr(6'h2A, 8'hFF);
    rd(6'h18, 8'h04);
    rd(6'h19, 8'h36);
    rd(6'h2A, 8'h00);
    exp_out(5, 16'h0006);
    exp_out(4, 16'h0001);
    exp_out(6, 16'h0001);
    for (int c = 0; c < 4; c++) begin
      wr(6'h19, {2'h3, 1'b1, c[1:0], 1'b1, c[1:0]});
      wr(6'h18, {4'h0, 2'h1, c[0], c[1]});
      drv(1'b0, 1'b0, 1'b1);
      exp_out(5, 16'(2 * c + 2));
      exp_out(4, 16'h0001);
      exp_out(6, {15'h0000, c != 0});
      exp_out(7, clamp_exp(c[1:0]));
      exp_out(2, {15'h0000, c[1]});
      exp_out(3, {15'h0000, c[0]});
      drv(1'b1, 1'b1, 1'b0);
      exp_out(4, 16'h0000);
      exp_out(5, 16'h0001);
      exp_out(2, 16'h0001);
      exp_out(7, clamp_exp(c[1:0]));
      wr(6'h19, {2'h3, 1'b0, c[1:0], 1'b0, c[1:0]});
      drv(1'b0, 1'b1, 1'b0);
      exp_out(5, 16'(2 * c + 2));
      exp_out(4, 16'h0000);
      rd(6'h19, {2'h0, 1'b0, c[1:0], 1'b0, c[1:0]});
    end
    wr(6'h19, 8'h14);
    drv(1'b0, 1'b0, 1'b0);
    exp_out(6, 16'h0000);
    exp_out(7, 16'h0000);
    exp_out(5, 16'h0006);
    for (int w = 0; w < 4; w++) begin
      wr(6'h18, {4'hF, w[1:0], 2'h0});
      rd(6'h18, {4'h0, w[1:0], 2'h0});
      exp_out(1, 16'h0001);
      @(posedge sys_clk_i);
      osc_stable_i <= 1'b1;
      cnt = 0;
      #1;
      while (chip_ready_low_o !== 1'b0 && cnt < 20000) begin
        #4;
        cnt++;
      end
      lim = 64 << (w == 0 ? 0 : 2 * w + 2);
      in_range = cnt >= lim && cnt <= lim + 8;
      exp_out(8, 16'h0001);
      @(posedge sys_clk_i);
      osc_stable_i <= 1'b0;
      repeat (5) @(posedge sys_clk_i);
      #1 exp_out(1, 16'h0001);
    end
    print_verdict;
  end
endmodule
